/* rtl/ohp_top.sv */
/*
   Overcurrent fault filter, fault latch and hiccup restart sequencer.
   Assumes every input is an asynchronous level from analogue comparators, and that
   cycle_strobe_in rises once per switching cycle, after the sense window closes.
*/
`timescale 1ns/100ps
module ohp_top (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic overcurrent_trip_in,
   input wire logic cycle_strobe_in,
   input wire logic supply_uvlo_in,
   input wire logic supply_below_restart_in,
   input wire logic supply_on_in,
   output logic gate_enable_out,
   output logic warning_out,
   output logic fault_latched_out,
   output logic startup_enable_out
);
   logic rst_meta;
   logic rst_n;
   logic trip_s;
   logic strobe_s;
   logic uvlo_s;
   logic below_restart_s;
   logic on_s;
   logic strobe_d;
   logic cycle_end;
   logic trip_seen;
   ohp_pkg::ohp_state_t state;
   ohp_pkg::ohp_supply_t supply;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   logic [4:0] raw;
   logic [4:0] synced;
   assign raw = {overcurrent_trip_in, cycle_strobe_in, supply_uvlo_in,
                 supply_below_restart_in, supply_on_in};
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         ohp_sync u_sync (
            .clk_in(clk_in),
            .reset_n_in(rst_n),
            .d_in(raw[gi]),
            .q_out(synced[gi])
         );
      end
   endgenerate
   assign trip_s = synced[4];
   assign strobe_s = synced[3];
   assign uvlo_s = synced[2];
   assign below_restart_s = synced[1];
   assign on_s = synced[0];

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         strobe_d <= 1'b0;
      end else begin
         strobe_d <= strobe_s;
      end
   end
   assign cycle_end = strobe_s && !strobe_d;

   // A trip only counts while the converter switches; outside RUN the gate is off anyway.
   logic cycle_trip;
   assign cycle_trip = cycle_end && (trip_seen || (trip_s && supply == ohp_pkg::OHP_RUN));

   // A trip anywhere inside a switching cycle is held until that cycle's strobe.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         trip_seen <= 1'b0;
      end else if (cycle_end) begin
         trip_seen <= 1'b0;
      end else if (trip_s && supply == ohp_pkg::OHP_RUN) begin
         trip_seen <= 1'b1;
      end
   end

   // Fault filter and latch; the filter is evaluated once per switching cycle, the latch clears on uvlo_s at any clock.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= ohp_pkg::OHP_IDLE;
      end else begin
         unique case (state)
            ohp_pkg::OHP_IDLE: begin
               if (cycle_trip) begin
                  state <= ohp_pkg::OHP_WARN;
               end
            end
            ohp_pkg::OHP_WARN: begin
               if (cycle_end) begin
                  if (cycle_trip) begin
                     state <= ohp_pkg::OHP_FAULT;
                  end else begin
                     state <= ohp_pkg::OHP_IDLE;
                  end
               end
            end
            ohp_pkg::OHP_FAULT: begin
               if (uvlo_s) begin
                  state <= ohp_pkg::OHP_IDLE;
               end
            end
            default: begin
               state <= ohp_pkg::OHP_IDLE;
            end
         endcase
      end
   end

   // Supply sequencer: run, drain after a fault until restart level, then recharge.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         supply <= ohp_pkg::OHP_RUN;
      end else begin
         unique case (supply)
            ohp_pkg::OHP_RUN: begin
               if (state == ohp_pkg::OHP_WARN && cycle_trip) begin
                  supply <= ohp_pkg::OHP_DRAIN;
               end
            end
            ohp_pkg::OHP_DRAIN: begin
               if (below_restart_s && state != ohp_pkg::OHP_FAULT) begin
                  supply <= ohp_pkg::OHP_CHARGE;
               end
            end
            ohp_pkg::OHP_CHARGE: begin
               if (on_s) begin
                  supply <= ohp_pkg::OHP_RUN;
               end
            end
            default: begin
               supply <= ohp_pkg::OHP_RUN;
            end
         endcase
      end
   end

   // Outputs are registered decodes of the current state and supply phase, one clock behind them.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gate_enable_out <= 1'b0;
         warning_out <= 1'b0;
         fault_latched_out <= 1'b0;
         startup_enable_out <= 1'b0;
      end else begin
         gate_enable_out <= supply == ohp_pkg::OHP_RUN && state != ohp_pkg::OHP_FAULT;
         warning_out <= state == ohp_pkg::OHP_WARN;
         fault_latched_out <= state == ohp_pkg::OHP_FAULT;
         startup_enable_out <= supply == ohp_pkg::OHP_CHARGE;
      end
   end

   property p_idle_to_warn;
      @(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_IDLE && supply == ohp_pkg::OHP_RUN
         && cycle_end && (trip_seen || trip_s)
         |=> state == ohp_pkg::OHP_WARN ##1 warning_out && gate_enable_out;
   endproperty
   a_idle_to_warn: assert property (p_idle_to_warn) else $error("trip did not warn");
   property p_warn_clean;
      @(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_WARN && cycle_end && !trip_seen && !trip_s
         |=> state == ohp_pkg::OHP_IDLE;
   endproperty
   a_warn_clean: assert property (p_warn_clean) else $error("clean cycle kept warning");
   property p_warn_fault;
      @(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_WARN && cycle_end && (trip_seen || trip_s)
         |=> ##1 fault_latched_out && !gate_enable_out;
   endproperty
   a_warn_fault: assert property (p_warn_fault) else $error("second trip kept gate on");
   property p_hold;
      @(posedge clk_in) disable iff (!rst_n)
      supply == ohp_pkg::OHP_DRAIN && !below_restart_s |=> !gate_enable_out;
   endproperty
   a_hold: assert property (p_hold) else $error("switching resumed above restart");
   property p_uvlo_clear;
      @(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_FAULT && uvlo_s |=> state == ohp_pkg::OHP_IDLE ##1 !fault_latched_out;
   endproperty
   a_uvlo_clear: assert property (p_uvlo_clear) else $error("uvlo did not clear latch");
   property p_startup_off;
      @(posedge clk_in) disable iff (!rst_n)
      supply == ohp_pkg::OHP_DRAIN && !below_restart_s |=> !startup_enable_out;
   endproperty
   a_startup_off: assert property (p_startup_off) else $error("start-up on early");
   property p_restart;
      @(posedge clk_in) disable iff (!rst_n)
      supply == ohp_pkg::OHP_CHARGE && on_s |=> ##1 gate_enable_out && !warning_out;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not clean");
   property p_trip_held;
      @(posedge clk_in) disable iff (!rst_n)
      trip_s && !cycle_end && supply == ohp_pkg::OHP_RUN |=> trip_seen;
   endproperty
   a_trip_held: assert property (p_trip_held) else $error("trip not captured");
   property p_trip_refused;
      @(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_IDLE && supply != ohp_pkg::OHP_RUN |=> state == ohp_pkg::OHP_IDLE;
   endproperty
   a_trip_refused: assert property (p_trip_refused) else $error("trip counted while off");
   property p_fault_gate_off;
      @(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_FAULT |=> !gate_enable_out && fault_latched_out;
   endproperty
   a_fault_gate_off: assert property (p_fault_gate_off) else $error("gate on in fault");
   c_warn: cover property (@(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_WARN ##[1:200] state == ohp_pkg::OHP_IDLE);
   c_fault: cover property (@(posedge clk_in) disable iff (!rst_n)
      state == ohp_pkg::OHP_FAULT);
   c_restart: cover property (@(posedge clk_in) disable iff (!rst_n)
      supply == ohp_pkg::OHP_CHARGE ##1 supply == ohp_pkg::OHP_RUN);
   c_refused: cover property (@(posedge clk_in) disable iff (!rst_n)
      cycle_end && trip_s && supply != ohp_pkg::OHP_RUN);
endmodule // ohp_top

/* rtl/ohp_pkg.sv */
/*
   Constants of the overcurrent hiccup protection block: state codes, supply phase codes
   and the analogue trip level figure that the sense comparator is built to.
   Assumes the comparators and supply monitors outside deliver plain digital levels.
*/
// Behaviour
// - The sense comparator, tripping above the 1 V level, is watched and fed to the logic.
// - A trip seen while idle in the run phase moves the logic to a warning state and the gate keeps switching.
// - In warning, a following switching cycle without a trip returns the logic to idle.
// - In warning, a trip in the following switching cycle declares a fault and stops the gate.
// - A declared fault stays latched and switching stays off above the restart level.
// - The fault latch clears when the supply falls below the undervoltage lockout threshold.
// - Once cleared, start-up waits for the restart level, then recharges and restarts.
package ohp_pkg;
   // Trip level of the sense comparator in millivolts, kept for reference.
   localparam int OHP_TRIP_LEVEL_MV = 1000;
   typedef enum logic [2:0] {
      OHP_IDLE = 3'h1,
      OHP_WARN = 3'h2,
      OHP_FAULT = 3'h4
   } ohp_state_t;
   typedef enum logic [2:0] {
      OHP_RUN = 3'h1,
      OHP_DRAIN = 3'h2,
      OHP_CHARGE = 3'h4
   } ohp_supply_t;
endpackage

/* rtl/ohp_sync.sv */
/*
   Two flip-flop synchroniser for one level.
   Assumes an active-low asynchronous reset already released on clk_in.
*/
`timescale 1ns/100ps
module ohp_sync (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic d_in,
   output logic q_out
);
   logic stage1;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stage1 <= 1'b0;
         q_out <= 1'b0;
      end else begin
         stage1 <= d_in;
         q_out <= stage1;
      end
   end
endmodule // ohp_sync

/* verif/ohp_top_tb_top.sv */
/*
   Self-checking bench for the overcurrent hiccup protection block.
   Assumes the block's inputs are plain levels that it synchronises itself.
*/
`timescale 1ns/100ps
module ohp_top_tb_top;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic trip = 1'b0;
   logic strobe = 1'b0;
   logic uvlo = 1'b0;
   logic below = 1'b0;
   logic son = 1'b0;
   logic gate, warn, fault, start;
   logic [3:0] notes[$];
   int failures = 0;
   int checks = 0;
   logic w = 1'b0;
   int m;
   event sample;

   always #20 clk_in = ~clk_in;

   ohp_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .overcurrent_trip_in(trip),
      .cycle_strobe_in(strobe), .supply_uvlo_in(uvlo), .supply_below_restart_in(below),
      .supply_on_in(son), .gate_enable_out(gate), .warning_out(warn),
      .fault_latched_out(fault), .startup_enable_out(start));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask

   // Outputs are packed as gate, warning, fault latch, start-up generator.
   task automatic note(input logic [3:0] v);
      tick(8);
      notes.push_back(v);
      -> sample;
      tick(1);
   endtask

   always begin
      logic [3:0] e;
      @(sample);
      e = notes.pop_front();
      checks++;
      if ({gate, warn, fault, start} !== e) begin
         failures++;
         $display("CHECK FAILED outputs expected %b seen %b", e, {gate, warn, fault, start});
      end
   end

   // Mode 0 is a clean cycle, 1 a trip held to the cycle end, 2 a short early trip.
   task automatic cyc(input int mode);
      trip = (mode != 0);
      tick(3);
      if (mode == 2) begin
         trip = 1'b0;
      end
      tick(2);
      strobe = 1'b1;
      // The trip ends one clock after the strobe, so in mode 1 it still stands at the cycle end.
      tick(1);
      trip = 1'b0;
      tick(2);
      strobe = 1'b0;
      tick(2);
   endtask

   task automatic recover();
      cyc(1);
      note(4'b0010);
      uvlo = 1'b1;
      note(4'b0000);
      cyc(1);
      note(4'b0000);
      below = 1'b1;
      note(4'b0001);
      uvlo = 1'b0;
      below = 1'b0;
      note(4'b0001);
      son = 1'b1;
      note(4'b1000);
      son = 1'b0;
      note(4'b1000);
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_in);
      failures++;
      summarize();
   end

   initial begin
      void'($urandom(4));
      tick(5);
      reset_n_in = 1'b1;
      note(4'b1000);
      $display("test reset done");
      cyc(1);
      note(4'b1100);
      cyc(0);
      note(4'b1000);
      cyc(2);
      note(4'b1100);
      cyc(1);
      note(4'b0010);
      recover();
      $display("test fixed sequence done");
      for (int i = 0; i < 16; i++) begin
         m = $urandom_range(2);
         cyc(m);
         if (m == 0) begin
            w = 1'b0;
            note(4'b1000);
         end else if (!w) begin
            w = 1'b1;
            note(4'b1100);
         end else begin
            w = 1'b0;
            note(4'b0010);
            recover();
         end
      end
      $display("test random cycles done");
      cyc(1);
      note(4'b1100);
      reset_n_in = 1'b0;
      note(4'b0000);
      reset_n_in = 1'b1;
      note(4'b1000);
      cyc(0);
      note(4'b1000);
      $display("test mid-run reset done");
      summarize();
   end
endmodule // ohp_top_tb_top
